// *** rtl/card_defs.svh ***
`ifndef CARD_DEFS_SVH
`define CARD_DEFS_SVH

// ****************************************
// command codes and address limits
// ****************************************
`define CMD_WR_PROT   8'h3C
`define CMD_RD_SEC    8'h31
`define CMD_UPD_SEC   8'h39
`define CMD_CMP       8'h33
`define PROT_ADDR_MAX 8'h1F
`define SEC_ADDR_MAX  8'h03
`define ERRC_ADDR     8'h00

// ****************************************
// command frame layout, lsb first on the line
// ****************************************
`define F_CTL      7:0
`define F_ADR      15:8
`define F_DAT      23:16
`define F_MADR     12:8
`define F_ERRC     2:0
`define CMD_BITS   5'h18
`define CMD_RISES  5'h19
`define CNT_MAX    5'h1F

// ****************************************
// security memory reset image, counter in byte 0
// ****************************************
`define SEC_INIT   32'hFFFFFF07
`define REF_HIDDEN 24'h000000
`define ERRC_PAD   5'h00

// ****************************************
// card clock pulse counts
// ****************************************
`define RD_BITS    9'h020
`define PROC_EW    9'h0FF
`define PROC_W     9'h07C
`define PROC_CMP   9'h002
`define PROC_MAX   9'h1FF

// ****************************************
// timing on the 100 ns reference clock
// ****************************************
`define CLK_PERIOD_NS 100
`define CARD_HALF_NS  10000
`define BREAK_NS      5000
`define HALF_CYC  ((`CARD_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BREAK_CYC ((`BREAK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** rtl/card_link_if.sv ***
`timescale 1ns/1ps
interface card_link_if;
  logic sclk;
  logic rst;
  logic term_io_o;
  logic term_io_oe;
  logic card_io_o;
  logic card_io_oe;
  logic io;

  // open drain with pull-up: low wins
  assign io = ~((term_io_oe & ~term_io_o) | (card_io_oe & ~card_io_o));

  modport card (input sclk, input rst, input io, output card_io_o, output card_io_oe);
  modport term (output sclk, output rst, output term_io_o, output term_io_oe, input io);
endinterface

// *** rtl/card_pkg.sv ***
package card_pkg;

  typedef enum logic [3:0] {
    C_IDLE = 4'h1,
    C_CMD  = 4'h2,
    C_OUT  = 4'h4,
    C_PROC = 4'h8
  } card_state_e;

  typedef enum logic [6:0] {
    T_IDLE  = 7'h01,
    T_BRK   = 7'h02,
    T_START = 7'h04,
    T_SEND  = 7'h08,
    T_STOP  = 7'h10,
    T_READ  = 7'h20,
    T_PROC  = 7'h40
  } term_state_e;

  typedef struct packed {
    card_state_e     state;
    logic            clk_m;
    logic            clk_s;
    logic            clk_p;
    logic            rst_m;
    logic            rst_s;
    logic            rst_p;
    logic            io_m;
    logic            io_s;
    logic            io_p;
    logic [23:0]     sr;
    logic [4:0]      cnt;
    logic [8:0]      pcnt;
    logic [8:0]      plen;
    logic [31:0]     out_sr;
    logic            io_oe;
    logic            fail;
    logic            armed;
    logic            unlocked;
    logic [1:0]      step;
    logic [3:0][7:0] secm;
    logic [31:0]     prot;
    logic [4:0]      main_addr;
    logic            p_sec;
    logic            p_prot;
    logic            p_unl;
    logic [4:0]      p_adr;
    logic [7:0]      p_val;
  } card_st_s;

  typedef struct packed {
    term_state_e state;
    logic [1:0]  ph;
    logic [6:0]  tcnt;
    logic [4:0]  bitn;
    logic [8:0]  pulses;
    logic        sclk;
    logic        rst;
    logic        io_oe;
    logic        io_m;
    logic        io_s;
    logic [23:0] sh;
    logic [7:0]  ctl;
    logic [31:0] rd;
    logic        busy;
    logic        done;
  } term_st_s;

endpackage

// *** rtl/card_sec_end.sv ***
`timescale 1ns/1ps
`include "card_defs.svh"
// How it works
// - protection write is 3C, address to 1F
// - security read sends four bytes, 32 pulses
// - one more pulse releases the data line
// - reference bytes read low until unlocked
// - security read is 31, address/data ignored
// - update 39 alters references only when unlocked
// - locked counter bits only go one to zero
// - processing 255 pulses erase+write, compare 2, else 124
// - compare 33 checks byte at address 1..3
// - compare outside a sequence verifies nothing
// - terminal clocks through compare processing
// - clear counter bit, then compare 1,2,3
// - counter data has upper five bits zero
// - counter never self-resets; erase proves unlock
// - unlock holds until power is removed
// - a compare mismatch in the sequence fails and stays locked
// - retry allowed while a counter bit remains
// - unlocked references rewrite like any byte
// - no alteration before a read or identity
// - reset high with clock low aborts
// - failure releases line within 8 pulses
// - failure causes listed, incl. protected rewrite
module card_sec_end (
  input  wire logic       I_REF_CLK,
  input  wire logic       I_NRST,
  card_link_if.card       LNK,
  input  wire logic [7:0] I_MAIN_BYTE,
  output logic      [4:0] O_MAIN_ADDR,
  output logic            O_UNLOCKED,
  output logic      [2:0] O_ERR_COUNT,
  output logic            O_FAIL
);
  import card_pkg::*;

  localparam card_st_s RST_ST = '{state: C_IDLE, secm: `SEC_INIT, default: '0};

  card_st_s s_r;
  card_st_s s_nxt;

  // ****************************************
  // line decode and command engine
  // ****************************************
  always_comb begin
    logic       rise;
    logic       fall;
    logic       brk;
    logic       start;
    logic       stop;
    logic       bad;
    logic [7:0] ctl;
    logic [7:0] adr;
    logic [7:0] dat;
    logic [7:0] old;
    logic [2:0] newc;
    logic [2:0] diff;
    rise  = s_r.clk_s & ~s_r.clk_p;
    fall  = ~s_r.clk_s & s_r.clk_p;
    brk   = s_r.rst_s & ~s_r.rst_p & ~s_r.clk_s;
    start = s_r.io_p & ~s_r.io_s & s_r.clk_s & ~s_r.rst_s;
    stop  = ~s_r.io_p & s_r.io_s & s_r.clk_s & ~s_r.rst_s;
    ctl   = s_r.sr[`F_CTL];
    adr   = s_r.sr[`F_ADR];
    dat   = s_r.sr[`F_DAT];
    old   = s_r.secm[adr[1:0]];
    newc  = s_r.secm[0][`F_ERRC] & dat[`F_ERRC];
    diff  = s_r.secm[0][`F_ERRC] ^ newc;
    bad   = 1'b0;
    s_nxt       = s_r;
    s_nxt.fail  = 1'b0;
    // pins cross in through two flops each
    s_nxt.clk_m = LNK.sclk;
    s_nxt.clk_s = s_r.clk_m;
    s_nxt.clk_p = s_r.clk_s;
    s_nxt.rst_m = LNK.rst;
    s_nxt.rst_s = s_r.rst_m;
    s_nxt.rst_p = s_r.rst_s;
    s_nxt.io_m  = LNK.io;
    s_nxt.io_s  = s_r.io_m;
    s_nxt.io_p  = s_r.io_s;
    if (brk) begin
      s_nxt.state  = C_IDLE;
      s_nxt.step   = 2'h0;
      s_nxt.p_sec  = 1'b0;
      s_nxt.p_prot = 1'b0;
      s_nxt.p_unl  = 1'b0;
    end else if (s_r.rst_s && rise) begin
      s_nxt.armed = 1'b1;
    end else begin
      unique case (s_r.state)
        C_IDLE: begin
          if (start) begin
            s_nxt.state = C_CMD;
            s_nxt.cnt   = 5'h00;
            s_nxt.sr    = '0;
          end
        end
        C_CMD: begin
          // address settles long before the stop
          s_nxt.main_addr = s_r.sr[`F_MADR];
          if (rise) begin
            if (s_r.cnt < `CMD_BITS) begin
              s_nxt.sr[s_r.cnt] = s_r.io_s;
            end
            if (s_r.cnt != `CNT_MAX) begin
              s_nxt.cnt = s_r.cnt + 5'h01;
            end
          end
          if (stop) begin
            s_nxt.state  = C_PROC;
            s_nxt.pcnt   = 9'h000;
            s_nxt.plen   = `PROC_W;
            s_nxt.p_adr  = adr[4:0];
            s_nxt.p_val  = (adr == `ERRC_ADDR) ? {`ERRC_PAD, dat[`F_ERRC]} : dat;
            // any other command breaks the sequence
            s_nxt.step   = 2'h0;
            if (s_r.cnt != `CMD_RISES) begin
              bad = 1'b1;
            end else begin
              case (ctl)
                `CMD_RD_SEC: begin
                  s_nxt.state  = C_OUT;
                  s_nxt.out_sr = s_r.unlocked ? s_r.secm : {`REF_HIDDEN, s_r.secm[0]};
                end
                `CMD_UPD_SEC: begin
                  if (!s_r.armed || adr > `SEC_ADDR_MAX) begin
                    bad = 1'b1;
                  end else if (s_r.unlocked) begin
                    s_nxt.p_sec = 1'b1;
                    if ((|(s_nxt.p_val & ~old)) && (|(~s_nxt.p_val & old))) begin
                      s_nxt.plen = `PROC_EW;
                    end
                  end else if (adr == `ERRC_ADDR) begin
                    s_nxt.p_sec = 1'b1;
                    s_nxt.p_val = {`ERRC_PAD, newc};
                    if (diff != 3'h0 && (diff & 3'(diff - 3'h1)) == 3'h0) begin
                      s_nxt.step = 2'h1;
                    end
                  end else begin
                    bad = 1'b1;
                  end
                end
                `CMD_CMP: begin
                  s_nxt.plen = `PROC_CMP;
                  if (adr > `SEC_ADDR_MAX) begin
                    bad = 1'b1;
                  end else if (s_r.step != 2'h0 && adr[1:0] == s_r.step) begin
                    if (dat != old) begin
                      bad = 1'b1;
                    end else if (s_r.step == 2'h3) begin
                      s_nxt.p_unl = 1'b1;
                    end else begin
                      s_nxt.step = s_r.step + 2'h1;
                    end
                  end
                end
                `CMD_WR_PROT: begin
                  if (!s_r.armed || adr > `PROT_ADDR_MAX || s_r.prot[adr[4:0]]) begin
                    bad = 1'b1;
                  end else if (dat == I_MAIN_BYTE) begin
                    s_nxt.p_prot = 1'b1;
                  end
                end
                default: begin
                  bad = 1'b1;
                end
              endcase
            end
            if (bad) begin
              // release at once, well inside 8
              s_nxt.state  = C_IDLE;
              s_nxt.fail   = 1'b1;
              s_nxt.step   = 2'h0;
              s_nxt.p_sec  = 1'b0;
              s_nxt.p_prot = 1'b0;
              s_nxt.p_unl  = 1'b0;
            end
          end
        end
        C_OUT: begin
          if (fall && s_r.pcnt != 9'h000) begin
            s_nxt.out_sr = s_r.out_sr >> 1;
          end
          if (rise) begin
            if (s_r.pcnt == `RD_BITS) begin
              s_nxt.state = C_IDLE;
              s_nxt.armed = 1'b1;
            end else begin
              s_nxt.pcnt = s_r.pcnt + 9'h001;
            end
          end
        end
        C_PROC: begin
          // commit on the last processing pulse
          if (rise) begin
            if (9'(s_r.pcnt + 9'h001) >= s_r.plen) begin
              s_nxt.state = C_IDLE;
              if (s_r.p_sec) begin
                s_nxt.secm[s_r.p_adr[1:0]] = s_r.p_val;
              end
              if (s_r.p_prot) begin
                s_nxt.prot[s_r.p_adr] = 1'b1;
              end
              if (s_r.p_unl) begin
                s_nxt.unlocked = 1'b1;
              end
              s_nxt.p_sec  = 1'b0;
              s_nxt.p_prot = 1'b0;
              s_nxt.p_unl  = 1'b0;
            end else begin
              s_nxt.pcnt = s_r.pcnt + 9'h001;
            end
          end
        end
      endcase
    end
    // busy holds the line low; reads pull low on zeros
    s_nxt.io_oe = (s_nxt.state == C_PROC) || (s_nxt.state == C_OUT && !s_nxt.out_sr[0]);
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      s_r <= RST_ST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign LNK.card_io_o  = 1'h0;
  assign LNK.card_io_oe = s_r.io_oe;
  assign O_MAIN_ADDR    = s_r.main_addr;
  assign O_UNLOCKED     = s_r.unlocked;
  assign O_ERR_COUNT    = s_r.secm[0][`F_ERRC];
  assign O_FAIL         = s_r.fail;

endmodule // card_sec_end

// *** rtl/card_term_end.sv ***
`timescale 1ns/1ps
`include "card_defs.svh"
module card_term_end (
  input  wire logic        I_REF_CLK,
  input  wire logic        I_NRST,
  card_link_if.term        LNK,
  input  wire logic        I_CMD_GO,
  input  wire logic [7:0]  I_CMD_CTRL,
  input  wire logic [7:0]  I_CMD_ADDR,
  input  wire logic [7:0]  I_CMD_DATA,
  input  wire logic        I_BREAK,
  output logic             O_BUSY,
  output logic             O_DONE,
  output logic [31:0]      O_RD_DATA
);
  import card_pkg::*;

  localparam term_st_s RST_ST = '{state: T_IDLE, default: '0};

  term_st_s s_r;
  term_st_s s_nxt;

  // ****************************************
  // sequencer, one step per card half period
  // ****************************************
  always_comb begin
    logic tick;
    tick          = (s_r.tcnt == 7'(`HALF_CYC - 1));
    s_nxt         = s_r;
    s_nxt.done    = 1'b0;
    s_nxt.io_m    = LNK.io;
    s_nxt.io_s    = s_r.io_m;
    s_nxt.tcnt    = tick ? 7'h00 : s_r.tcnt + 7'h01;
    if (tick) begin
      s_nxt.ph = s_r.ph + 2'h1;
    end
    unique case (s_r.state)
      T_IDLE: begin
        s_nxt.tcnt = 7'h00;
        s_nxt.ph   = 2'h0;
        if (I_BREAK) begin
          s_nxt.rst   = 1'b1;
          s_nxt.busy  = 1'b1;
          s_nxt.state = T_BRK;
        end else if (I_CMD_GO) begin
          s_nxt.sh    = {I_CMD_DATA, I_CMD_ADDR, I_CMD_CTRL};
          s_nxt.ctl   = I_CMD_CTRL;
          s_nxt.rd    = '0;
          s_nxt.busy  = 1'b1;
          s_nxt.state = T_START;
        end
      end
      T_BRK: begin
        // hold at least the pulse width
        if (s_r.tcnt == 7'(`BREAK_CYC - 1)) begin
          s_nxt.rst   = 1'b0;
          s_nxt.busy  = 1'b0;
          s_nxt.done  = 1'b1;
          s_nxt.state = T_IDLE;
        end
      end
      T_START: begin
        if (tick) begin
          if (s_r.ph == 2'h0) begin
            s_nxt.sclk = 1'b1;
          end else if (s_r.ph == 2'h1) begin
            s_nxt.io_oe = 1'b1;
          end else begin
            s_nxt.sclk  = 1'b0;
            s_nxt.ph    = 2'h0;
            s_nxt.bitn  = 5'h00;
            s_nxt.state = T_SEND;
          end
        end
      end
      T_SEND: begin
        if (tick) begin
          if (s_r.ph == 2'h0) begin
            s_nxt.io_oe = ~s_r.sh[0];
          end else if (s_r.ph == 2'h1) begin
            s_nxt.sclk = 1'b1;
          end else begin
            s_nxt.sclk = 1'b0;
            s_nxt.sh   = s_r.sh >> 1;
            s_nxt.bitn = s_r.bitn + 5'h01;
            s_nxt.ph   = 2'h0;
            if (s_r.bitn == 5'(`CMD_BITS - 5'h01)) begin
              s_nxt.state = T_STOP;
            end
          end
        end
      end
      T_STOP: begin
        if (tick) begin
          if (s_r.ph == 2'h0) begin
            s_nxt.io_oe = 1'b1;
          end else if (s_r.ph == 2'h1) begin
            s_nxt.sclk = 1'b1;
          end else if (s_r.ph == 2'h2) begin
            s_nxt.io_oe = 1'b0;
          end else begin
            s_nxt.sclk   = 1'b0;
            s_nxt.ph     = 2'h0;
            s_nxt.pulses = '0;
            s_nxt.state  = (s_r.ctl == `CMD_RD_SEC) ? T_READ : T_PROC;
          end
        end
      end
      T_READ: begin
        if (tick) begin
          if (s_r.ph == 2'h0) begin
            s_nxt.sclk   = 1'b1;
            s_nxt.pulses = s_r.pulses + 9'h001;
            if (s_r.pulses < `RD_BITS) begin
              s_nxt.rd = {s_r.io_s, s_r.rd[31:1]};
            end
          end else begin
            s_nxt.sclk = 1'b0;
            s_nxt.ph   = 2'h0;
            if (s_r.pulses > `RD_BITS) begin
              s_nxt.busy  = 1'b0;
              s_nxt.done  = 1'b1;
              s_nxt.state = T_IDLE;
            end
          end
        end
      end
      T_PROC: begin
        // clock until the card lets go
        if (tick) begin
          if (s_r.ph == 2'h0) begin
            if (s_r.io_s || s_r.pulses == `PROC_MAX) begin
              s_nxt.busy  = 1'b0;
              s_nxt.done  = 1'b1;
              s_nxt.state = T_IDLE;
            end else begin
              s_nxt.sclk   = 1'b1;
              s_nxt.pulses = s_r.pulses + 9'h001;
            end
          end else begin
            s_nxt.sclk = 1'b0;
            s_nxt.ph   = 2'h0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      s_r <= RST_ST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign LNK.sclk       = s_r.sclk;
  assign LNK.rst        = s_r.rst;
  assign LNK.term_io_o  = 1'h0;
  assign LNK.term_io_oe = s_r.io_oe;
  assign O_BUSY         = s_r.busy;
  assign O_DONE         = s_r.done;
  assign O_RD_DATA      = s_r.rd;

endmodule // card_term_end

// *** verif/card_link_assertions.sv ***
`timescale 1ns/1ps
// ****************************************
// wire checker, decodes frames from the pins
// ****************************************
module card_link_assertions (
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  input wire logic sclk,
  input wire logic rst,
  input wire logic term_io_oe,
  input wire logic card_io_oe,
  input wire logic io
);
  logic        sclk_q;
  logic        toe_q;
  logic [1:0]  phase;
  logic [5:0]  nbits;
  logic [23:0] sh;
  logic [8:0]  rises;
  logic [6:0]  rst_cnt;
  logic        stop_ev;
  logic        sclk_up;
  logic [7:0]  ctl;
  logic        known;

  assign stop_ev = sclk & toe_q & ~term_io_oe;
  assign sclk_up = sclk & ~sclk_q;
  assign ctl     = sh[7:0];
  assign known   = (ctl == 8'h31) | (ctl == 8'h33) | (ctl == 8'h39) | (ctl == 8'h3C);

  // stop pulse rise is not shifted, so ctl stays aligned
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      sclk_q  <= 1'b0;
      toe_q   <= 1'b0;
      phase   <= 2'h0;
      nbits   <= 6'h00;
      sh      <= 24'h000000;
      rises   <= 9'h000;
      rst_cnt <= 7'h00;
    end else begin
      sclk_q  <= sclk;
      toe_q   <= term_io_oe;
      rst_cnt <= rst ? rst_cnt + 7'h01 : 7'h00;
      if (rst) begin
        phase <= 2'h0;
      end else if (sclk && term_io_oe && !toe_q) begin
        phase <= 2'h1;
        nbits <= 6'h00;
      end else if (stop_ev) begin
        phase <= 2'h2;
        rises <= 9'h000;
      end else if (sclk_up && phase == 2'h1 && nbits < 6'h18) begin
        sh    <= {io, sh[23:1]};
        nbits <= nbits + 6'h01;
      end else if (sclk_up && phase == 2'h2) begin
        rises <= rises + 9'h001;
      end
    end
  end

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);

  property p_frame_len;
    stop_ev |-> nbits == 6'h18;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame not 24 bits at stop");

  property p_read_release;
    phase == 2'h2 && ctl == 8'h31 && sclk_up && rises == 9'h020 |-> ##[1:6] !card_io_oe;
  endproperty
  a_read_release: assert property (p_read_release) else $error("read not released");

  property p_ctr_pad;
    phase == 2'h2 && ctl == 8'h31 && sclk_up && rises inside {[9'h003:9'h007]} |-> !io;
  endproperty
  a_ctr_pad: assert property (p_ctr_pad) else $error("counter pad bit not low");

  property p_upd_len;
    $fell(card_io_oe) && phase == 2'h2 && ctl == 8'h39
      |-> rises == 9'h000 || rises == 9'h07C || rises == 9'h0FF;
  endproperty
  a_upd_len: assert property (p_upd_len) else $error("update length wrong");

  property p_cmp_len;
    $fell(card_io_oe) && phase == 2'h2 && ctl == 8'h33 |-> rises == 9'h000 || rises == 9'h002;
  endproperty
  a_cmp_len: assert property (p_cmp_len) else $error("compare length wrong");

  property p_fail_release;
    stop_ev && !known |-> ##8 !card_io_oe;
  endproperty
  a_fail_release: assert property (p_fail_release) else $error("line held after failure");

  property p_break_release;
    $rose(rst) && !sclk |-> ##[1:6] !card_io_oe;
  endproperty
  a_break_release: assert property (p_break_release) else $error("break kept line");

  property p_break_width;
    $fell(rst) |-> rst_cnt >= 7'h32;
  endproperty
  a_break_width: assert property (p_break_width) else $error("break pulse too short");

  property p_break_clk_low;
    $rose(rst) |-> !sclk;
  endproperty
  a_break_clk_low: assert property (p_break_clk_low) else $error("break with clock high");
endmodule // card_link_assertions

// *** verif/test_card_security_command_logic.sv ***
`timescale 1ns/1ps
module test_card_security_command_logic;
  import card_pkg::*;
  logic        clk;
  logic        nrst;
  logic        go;
  logic [7:0]  ctrl;
  logic [7:0]  addr;
  logic [7:0]  data;
  logic        brk;
  logic [7:0]  main_byte;
  logic        busy;
  logic        done;
  logic [31:0] rd_data;
  logic [4:0]  main_addr;
  logic        unlocked;
  logic [2:0]  err_count;
  logic        fail;
  int          errors;
  int          comparisons;
  int          cycles;
  int          fails_seen;
  int          ctr;
  int          step;
  int          mfail;
  bit          armed;
  bit          unl;
  int          refs[$];

  card_link_if lnk ();
  card_term_end u_card_term_end (.I_REF_CLK(clk), .I_NRST(nrst), .LNK(lnk), .I_CMD_GO(go),
    .I_CMD_CTRL(ctrl), .I_CMD_ADDR(addr), .I_CMD_DATA(data), .I_BREAK(brk), .O_BUSY(busy),
    .O_DONE(done), .O_RD_DATA(rd_data));
  card_sec_end u_card_sec_end (.I_REF_CLK(clk), .I_NRST(nrst), .LNK(lnk), .I_MAIN_BYTE(main_byte),
    .O_MAIN_ADDR(main_addr), .O_UNLOCKED(unlocked), .O_ERR_COUNT(err_count), .O_FAIL(fail));
  card_link_assertions u_card_link_assertions (.I_REF_CLK(clk), .I_NRST(nrst), .sclk(lnk.sclk),
    .rst(lnk.rst), .term_io_oe(lnk.term_io_oe), .card_io_oe(lnk.card_io_oe), .io(lnk.io));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // fail pulses counted, hang cut short
  always @(posedge clk) begin
    cycles++;
    if (fail === 1'b1) fails_seen++;
    if (cycles == 99000) begin
      errors++;
      $display("Error at %0t: run did not finish", $time);
      conclude();
    end
  end

  task automatic conclude();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 60000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 60000) begin
      errors++;
      $display("Error at %0t: no completion", $time);
      conclude();
    end
  endtask

  // reference model: arming, sequence step, counter, unlock
  task automatic model(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d);
    int nc;
    if (c == 8'h31) begin
      armed = 1;
      step = 0;
    end else if (c == 8'h39 && armed && a == 8'h00) begin
      nc = unl ? d[2:0] : (ctr & d[2:0]);
      step = ($countones(ctr) - $countones(nc) == 1) ? 1 : 0;
      ctr = nc;
    end else if (c == 8'h33 && armed && step != 0 && a == step) begin
      if (d != refs[a - 1]) begin
        mfail++;
        step = 0;
      end else if (step == 3) begin
        unl = 1;
        step = 0;
      end else begin
        step++;
      end
    end else if (c == 8'h33 && a <= 8'h03) begin
      step = 0;
    end else begin
      mfail++;
      step = 0;
    end
  endtask

  task automatic settle(input string name);
    chk({31'h0, unlocked}, {31'h0, unl}, "unlock state");
    chk({29'h0, err_count}, 32'(ctr), "error counter");
    chk(32'(fails_seen), 32'(mfail), "failure pulses");
    $display("test %s finished", name);
  endtask

  task automatic run(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d,
                     input string name);
    logic [31:0] exp;
    @(posedge clk);
    #10;
    go = 1'b1;
    ctrl = c;
    addr = a;
    data = d;
    @(posedge clk);
    #10;
    go = 1'b0;
    chk({31'h0, busy}, 32'h1, "busy after take");
    wait_done();
    model(c, a, d);
    exp = {unl ? 8'(refs[2]) : 8'h00, unl ? 8'(refs[1]) : 8'h00,
           unl ? 8'(refs[0]) : 8'h00, 8'(ctr)};
    if (c == 8'h31) chk(rd_data, exp, "read data");
    chk({31'h0, busy}, 32'h0, "busy at done");
    chk({27'h0, main_addr}, {27'h0, a[4:0]}, "main address");
    settle(name);
  endtask

  task automatic brk_run();
    @(posedge clk);
    #10;
    brk = 1'b1;
    @(posedge clk);
    #10;
    brk = 1'b0;
    wait_done();
    step = 0;
    settle("break");
  endtask

  initial begin
    int k;
    logic [7:0] c;
    nrst = 1'b0;
    go = 1'b0;
    ctrl = 8'h00;
    addr = 8'h00;
    data = 8'h00;
    brk = 1'b0;
    main_byte = 8'h00;
    errors = 0;
    comparisons = 0;
    cycles = 0;
    fails_seen = 0;
    ctr = 7;
    step = 0;
    mfail = 0;
    armed = 0;
    unl = 0;
    refs = '{255, 255, 255};
    void'($urandom(99));
    main_byte = 8'($urandom());
    repeat (2) @(posedge clk);
    #10;
    nrst = 1'b1;
    run(8'h39, 8'h00, 8'h06, "write before arming");
    run(8'h3C, 8'($urandom_range(31, 0)), main_byte, "protect before arming");
    do c = 8'($urandom()); while (c inside {8'h31, 8'h33, 8'h39, 8'h3C});
    run(c, 8'($urandom()), 8'($urandom()), "unknown command");
    brk_run();
    run(8'h31, 8'($urandom()), 8'($urandom()), "locked read");
    k = $urandom_range(2, 0);
    run(8'h39, 8'h00, 8'h07 & ~(8'h01 << k), "counter bit clear");
    for (int i = 1; i <= 3; i++) run(8'h33, 8'(i), 8'(refs[i - 1]), "compare");
    conclude();
  end
endmodule // test_card_security_command_logic
